/* File: rtl/ctmr_timer.sv */
// Compact 10-bit count-up timer: compare-match output, PWM and
// timer/counter modes, with an APB register slave.
// Assumes a 100 MHz clk; timer counts on every clock (clock select
// is not modelled). APB answers with no wait states.
//
// Contract
// R01: Coarse field compared with count bits 9..7
// R02: Coarse zero means run to overflow, 1024
// R03: Clear select 0 clears on coarse match
// R04: Clear select 1 clears on fine match
// R05: PWM ignores clear select; swap bit decides
// R06: Mode field selects compare, PWM, timer
// R07: Software stops timer before changing mode
// R08: Timer mode: level and polarity have no effect
// R09: Compare mode: action none, low, high, toggle
// R10: PWM action: inactive, active, waveform
// R11: Drive equal to initial level shows nothing
// R12: Timer on rising restores initial pin level
// R13: Software changes PWM action only when off
// R14: Initial level: start level or active sense
// R15: Polarity bit inverts output pin
// R16: Swap bit exchanges period and duty comparators
// R17: Counter readable as low and high bytes
// R18: Fine compare value in RW bytes, reset zero
// R19: Timer on rising clears counter; falling keeps
// R20: Fine clear select suppresses coarse match flag
// R21: Duty at or above period gives full duty
// R22: Counter increments each clock, wraps at max
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps

module ctmr_timer (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             timerOutputPin
);
   import ctmr_pkg::*;

   // ***************************************************************
   // Registers
   // ***************************************************************
   logic [7:0]            ctrl0_reg;
   logic [7:0]            ctrl1_reg;
   logic [CTMR_CNT_W-1:0] fineCompare_reg;
   logic [CTMR_CNT_W-1:0] count_reg;
   logic [CTMR_CNT_W-1:0] count_next;
   logic                  timerOnDly_reg;
   logic                  pinLevel_reg;
   logic                  pinLevel_next;
   logic                  fineMatchFlag_reg;
   logic                  coarseMatchFlag_reg;
   logic                  apbAccess_reg;

   // ***************************************************************
   // Field decode
   // ***************************************************************
   logic [2:0] coarsePeriodField;
   logic       timerOn;
   logic       pauseBit;
   logic       clearSelect;
   logic       periodDutySwap;
   logic       outputInvert;
   logic       initialLevel;
   logic [1:0] outputActionField;
   logic [1:0] modeField;

   assign coarsePeriodField = ctrl0_reg[CTMR_C0_PER_LSB +: 3];
   assign timerOn           = ctrl0_reg[CTMR_C0_ON_BIT];
   assign pauseBit          = ctrl0_reg[CTMR_C0_PAU_BIT];
   assign clearSelect       = ctrl1_reg[CTMR_C1_CCLR_BIT];
   assign periodDutySwap    = ctrl1_reg[CTMR_C1_DPX_BIT];
   assign outputInvert      = ctrl1_reg[CTMR_C1_POL_BIT];
   assign initialLevel      = ctrl1_reg[CTMR_C1_OC_BIT];
   assign outputActionField = ctrl1_reg[CTMR_C1_IO_LSB +: 2];
   assign modeField         = ctrl1_reg[CTMR_C1_MODE_LSB +: 2]; // see R06

   // ***************************************************************
   // Bus decode
   // ***************************************************************
   logic apbSetup;
   logic apbWrite;
   logic apbRead;
   logic addrMapped;

   assign apbSetup = psel && !penable;
   // Writes land at the completing access edge, with pready high
   assign apbWrite = psel && penable && apbAccess_reg && pwrite &&
                     addrMapped;
   assign apbRead  = apbSetup && !pwrite;

   always_comb begin
      unique case (paddr)
         CTMR_ADDR_CTRL0, CTMR_ADDR_CTRL1, CTMR_ADDR_CNT_LO,
         CTMR_ADDR_CNT_HI, CTMR_ADDR_FCV_LO, CTMR_ADDR_FCV_HI,
         CTMR_ADDR_STAT: addrMapped = 1'b1;
         default:        addrMapped = 1'b0;
      endcase
   end

   // ***************************************************************
   // Comparators
   // ***************************************************************
   logic timerStart;
   logic running;
   logic coarseMatch;
   logic fineMatch;
   logic overflow;
   logic coarseEvent;
   logic clearOnFine;
   logic pwmMode;
   logic [CTMR_CNT_W:0] coarseValue;
   logic [CTMR_CNT_W:0] periodValue;
   logic [CTMR_CNT_W:0] dutyValue;

   assign timerStart  = timerOn && !timerOnDly_reg;
   assign running     = timerOn && !pauseBit && timerOnDly_reg;
   assign pwmMode     = (modeField == CTMR_MODE_PWM);
   assign overflow    = (count_reg == CTMR_CNT_MAX);
   // Match when count reaches the value just below the boundary
   assign coarseMatch = (coarsePeriodField != 3'h0) &&
                        (count_reg[9:7] == coarsePeriodField - 3'h1) &&
                        (count_reg[6:0] == 7'h7F); // see R01
   // A zero coarse field makes overflow stand in for the match
   assign coarseEvent = coarseMatch ||
                        ((coarsePeriodField == 3'h0) && overflow); // see R02
   assign fineMatch   = (fineCompare_reg != 10'h000) &&
                        (count_reg == fineCompare_reg - 10'h001);
   assign clearOnFine = pwmMode ? periodDutySwap : clearSelect; // see R05

   assign coarseValue = (coarsePeriodField == 3'h0) ? 11'h400 :
                        {1'b0, coarsePeriodField, 7'h00};
   // Roles of the comparators in PWM mode
   assign periodValue = periodDutySwap ? {1'b0, fineCompare_reg} :
                        coarseValue; // see R16
   assign dutyValue   = periodDutySwap ? coarseValue :
                        {1'b0, fineCompare_reg}; // see R16

   // ***************************************************************
   // Counter
   // ***************************************************************
   always_comb begin
      count_next = count_reg;
      if (timerStart) begin
         count_next = CTMR_RST_COUNT; // see R19
      end else if (running) begin
         if (clearOnFine && fineMatch) begin
            count_next = CTMR_RST_COUNT; // see R04
         end else if (!clearOnFine && coarseEvent) begin
            count_next = CTMR_RST_COUNT; // see R03
         end else begin
            count_next = count_reg + 10'h001; // see R22
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_reg <= CTMR_RST_COUNT;
      end else begin
         count_reg <= count_next;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         timerOnDly_reg <= 1'b0;
      end else begin
         timerOnDly_reg <= timerOn;
      end
   end

   // ***************************************************************
   // Match flags: set wins over software clear
   // ***************************************************************
   logic flagClrWrite;

   assign flagClrWrite = apbWrite && (paddr == CTMR_ADDR_STAT);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fineMatchFlag_reg <= 1'b0;
      end else if (running && fineMatch) begin
         fineMatchFlag_reg <= 1'b1;
      end else if (flagClrWrite && pwdata[CTMR_ST_FMF_BIT]) begin
         fineMatchFlag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         coarseMatchFlag_reg <= 1'b0;
      end else if (running && coarseEvent && !clearOnFine) begin // see R20
         coarseMatchFlag_reg <= 1'b1;
      end else if (flagClrWrite && pwdata[CTMR_ST_CMF_BIT]) begin
         coarseMatchFlag_reg <= 1'b0;
      end
   end

   // ***************************************************************
   // Output pin
   // ***************************************************************
   logic pwmActive;

   // Duty at or above period keeps the output active all period
   assign pwmActive = ({1'b0, count_reg} < dutyValue) ||
                      (dutyValue >= periodValue); // see R21

   always_comb begin
      pinLevel_next = pinLevel_reg;
      if (timerStart) begin
         pinLevel_next = initialLevel; // see R12
      end else if (modeField == CTMR_MODE_CMP) begin
         if (running && fineMatch) begin
            unique case (outputActionField) // see R09
               CTMR_ACT_NONE: pinLevel_next = pinLevel_reg;
               CTMR_ACT_LOW:  pinLevel_next = 1'b0; // see R11
               CTMR_ACT_HIGH: pinLevel_next = 1'b1; // see R11
               CTMR_ACT_TOG:  pinLevel_next = !pinLevel_reg;
            endcase
         end
      end else if (pwmMode) begin
         // Active level is the initial level bit
         unique case (outputActionField) // see R10
            CTMR_PWM_INACT: pinLevel_next = !initialLevel; // see R14
            CTMR_PWM_ACT:   pinLevel_next = initialLevel; // see R14
            CTMR_PWM_WAVE:  pinLevel_next = pwmActive ?
                                            initialLevel : !initialLevel;
            default:        pinLevel_next = pinLevel_reg;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pinLevel_reg <= 1'b0;
      end else begin
         pinLevel_reg <= pinLevel_next;
      end
   end

   // Timer/counter mode leaves the pin low, unaffected by level bits
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         timerOutputPin <= 1'b0;
      end else if (modeField == CTMR_MODE_TC) begin
         timerOutputPin <= 1'b0; // see R08
      end else begin
         timerOutputPin <= pinLevel_next ^ outputInvert; // see R15
      end
   end

   // ***************************************************************
   // Register writes
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl0_reg <= CTMR_RST_BYTE;
      end else if (apbWrite && paddr == CTMR_ADDR_CTRL0) begin
         ctrl0_reg <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl1_reg <= CTMR_RST_BYTE;
      end else if (apbWrite && paddr == CTMR_ADDR_CTRL1) begin
         ctrl1_reg <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fineCompare_reg <= CTMR_RST_COUNT; // see R18
      end else if (apbWrite && paddr == CTMR_ADDR_FCV_LO) begin
         fineCompare_reg[7:0] <= pwdata[7:0]; // see R18
      end else if (apbWrite && paddr == CTMR_ADDR_FCV_HI) begin
         fineCompare_reg[9:8] <= pwdata[1:0]; // see R18
      end
   end

   // ***************************************************************
   // APB read and handshake
   // ***************************************************************
   logic [7:0] readByte;

   always_comb begin
      readByte = 8'h00;
      unique case (paddr)
         CTMR_ADDR_CTRL0:  readByte = ctrl0_reg;
         CTMR_ADDR_CTRL1:  readByte = ctrl1_reg;
         CTMR_ADDR_CNT_LO: readByte = count_reg[7:0]; // see R17
         CTMR_ADDR_CNT_HI: readByte = {6'h00, count_reg[9:8]}; // see R17
         CTMR_ADDR_FCV_LO: readByte = fineCompare_reg[7:0];
         CTMR_ADDR_FCV_HI: readByte = {6'h00, fineCompare_reg[9:8]};
         CTMR_ADDR_STAT:   readByte = {5'h00, pinLevel_reg,
                                       coarseMatchFlag_reg,
                                       fineMatchFlag_reg};
         default:          readByte = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (apbRead) begin
         prdata <= {24'h00_0000, readByte};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         apbAccess_reg <= 1'b0;
         pready        <= 1'b0;
         pslverr       <= 1'b0;
      end else begin
         apbAccess_reg <= apbSetup;
         pready        <= apbSetup;
         pslverr       <= apbSetup && !addrMapped;
      end
   end

endmodule : ctmr_timer

/* File: shared/ctmr_pkg.sv */
// Constants for the compact 10-bit timer with compare and PWM output.
// Assumes a 32-bit APB slave; each byte register sits in its own word.
package ctmr_pkg;

   // ***************************************************************
   // Register byte addresses
   // ***************************************************************
   localparam logic [7:0] CTMR_ADDR_CTRL0  = 8'h00;
   localparam logic [7:0] CTMR_ADDR_CTRL1  = 8'h04;
   localparam logic [7:0] CTMR_ADDR_CNT_LO = 8'h08;
   localparam logic [7:0] CTMR_ADDR_CNT_HI = 8'h0C;
   localparam logic [7:0] CTMR_ADDR_FCV_LO = 8'h10;
   localparam logic [7:0] CTMR_ADDR_FCV_HI = 8'h14;
   localparam logic [7:0] CTMR_ADDR_STAT   = 8'h18;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   // Control 0: coarse period [2:0], timer on [3], pause [7]
   localparam int CTMR_C0_PER_LSB  = 0;
   localparam int CTMR_C0_ON_BIT   = 3;
   localparam int CTMR_C0_PAU_BIT  = 7;
   // Control 1 (timer_mode_output_control)
   localparam int CTMR_C1_CCLR_BIT = 0;
   localparam int CTMR_C1_DPX_BIT  = 1;
   localparam int CTMR_C1_POL_BIT  = 2;
   localparam int CTMR_C1_OC_BIT   = 3;
   localparam int CTMR_C1_IO_LSB   = 4;
   localparam int CTMR_C1_MODE_LSB = 6;
   // Status: fine match flag [0], coarse match flag [1], pin [2]
   localparam int CTMR_ST_FMF_BIT  = 0;
   localparam int CTMR_ST_CMF_BIT  = 1;
   localparam int CTMR_ST_PIN_BIT  = 2;

   // ***************************************************************
   // Reset values and sizes
   // ***************************************************************
   localparam logic [7:0] CTMR_RST_BYTE  = 8'h00;
   localparam logic [9:0] CTMR_RST_COUNT = 10'h000;
   localparam logic [9:0] CTMR_CNT_MAX   = 10'h3FF;
   localparam int         CTMR_CNT_W     = 10;

   // ***************************************************************
   // Encodings
   // ***************************************************************
   localparam logic [1:0] CTMR_MODE_CMP = 2'h0;
   localparam logic [1:0] CTMR_MODE_PWM = 2'h2;
   localparam logic [1:0] CTMR_MODE_TC  = 2'h3;

   localparam logic [1:0] CTMR_ACT_NONE = 2'h0;
   localparam logic [1:0] CTMR_ACT_LOW  = 2'h1;
   localparam logic [1:0] CTMR_ACT_HIGH = 2'h2;
   localparam logic [1:0] CTMR_ACT_TOG  = 2'h3;

   localparam logic [1:0] CTMR_PWM_INACT = 2'h0;
   localparam logic [1:0] CTMR_PWM_ACT   = 2'h1;
   localparam logic [1:0] CTMR_PWM_WAVE  = 2'h2;

endpackage : ctmr_pkg

/* File: tb/ctmr_timer_assertions.sv */
// Port checker for the compact timer: APB answers and output pin.
// Assumes it is bound into ctmr_timer and sees only its ports.
`timescale 1ns/1ps
module ctmr_timer_chk (
   input logic        clk,
   input logic        rst_n,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [7:0]  paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic        timerOutputPin
);
   import ctmr_pkg::*;
   // ****************
   // Shadow state
   // ****************
   logic [1:0] modeReg;
   logic [7:0] fcvLoReg;
   wire        setup  = psel && !penable;
   wire        access = psel && penable && pready;
   wire        mapped = paddr[1:0] == 2'h0 && paddr <= CTMR_ADDR_STAT;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         modeReg  <= 2'h0;
         fcvLoReg <= 8'h00;
      end else if (access && pwrite) begin
         if (paddr == CTMR_ADDR_CTRL1) modeReg <= pwdata[7:6];
         if (paddr == CTMR_ADDR_FCV_LO) fcvLoReg <= pwdata[7:0];
      end
   end
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_ready_follows: assert property (setup |=> pready)
      else $error("no ready after setup");
   chk_ready_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_ready_cause: assert property (pready |-> $past(setup))
      else $error("ready without setup");
   chk_err_decode: assert property (setup |=>
      pslverr == !$past(mapped))
      else $error("error flag does not match decode");
   chk_err_zero: assert property (pslverr && !pwrite |->
      prdata == 0)
      else $error("refused read not zero");
   chk_upper_zero: assert property (pready && !pwrite |->
      prdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   chk_hi_unused: assert property (pready && !pwrite &&
      (paddr == CTMR_ADDR_CNT_HI || paddr == CTMR_ADDR_FCV_HI) |->
      prdata[7:2] == 6'h00)
      else $error("unused high bits not zero");
   chk_fcv_echo: assert property (pready && !pwrite &&
      paddr == CTMR_ADDR_FCV_LO |-> prdata[7:0] == fcvLoReg)
      else $error("fine low byte readback wrong");
   chk_tc_pin_low: assert property (modeReg == CTMR_MODE_TC &&
      $past(modeReg) == CTMR_MODE_TC |-> !timerOutputPin)
      else $error("pin driven in timer mode");
   chk_idle_quiet: assert property (!psel |=> !pready && !pslverr)
      else $error("answer without request");
   cover property (setup && pwrite && paddr == CTMR_ADDR_FCV_LO);
   cover property (pslverr);
   cover property ($rose(timerOutputPin));
endmodule : ctmr_timer_chk

bind ctmr_timer ctmr_timer_chk chk_u (.clk, .rst_n, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timerOutputPin);

/* File: tb/ctmr_timer_tb_top.sv */
// Self-checking bench for the compact timer: registers, counter, pin.
// Assumes ctmr_timer with its checker bound; one 100 MHz clock.
`timescale 1ns/1ps
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin \
   failCount++; $display("wrong value %s exp %0h got %0h", n, e, g); \
   end end
module ctmr_timer_tb_top;
   import ctmr_pkg::*;
   logic        clk     = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        timerOutputPin;
   int          failCount   = 0;
   int          totalChecks = 0;
   always #5 clk = ~clk;
   ctmr_timer dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .timerOutputPin);
   // ****************
   // Bus tasks
   // ****************
   task automatic xfer(input logic [7:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic        e;
      xfer(a, 1'b1, {24'h00_0000, d}, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      xfer(a, 1'b0, 32'h0000_0000, q, e);
   endtask : rd
   task automatic cfg(input logic [7:0] c1, input logic [9:0] f,
      input logic [2:0] per);
      wr(CTMR_ADDR_CTRL0, 8'h00);
      wr(CTMR_ADDR_CTRL1, c1);
      wr(CTMR_ADDR_FCV_LO, f[7:0]);
      wr(CTMR_ADDR_FCV_HI, {6'h00, f[9:8]});
      wr(CTMR_ADDR_STAT, 8'h03);
      wr(CTMR_ADDR_CTRL0, {4'h0, 1'b1, per});
   endtask : cfg
   task automatic sweep(input logic [7:0] a, input int k,
      output logic [7:0] m);
      logic [31:0] q;
      m = 8'h00;
      repeat (k) begin
         rd(a, q);
         if (q[7:0] > m) m = q[7:0];
      end
   endtask : sweep
   // ****************
   // Scenarios
   // ****************
   task automatic testRegs();
      logic [31:0] q;
      logic        e;
      logic [7:0]  regs [5] = '{CTMR_ADDR_CTRL1, CTMR_ADDR_CNT_LO,
         CTMR_ADDR_CNT_HI, CTMR_ADDR_FCV_LO, CTMR_ADDR_FCV_HI};
      foreach (regs[i]) begin
         rd(regs[i], q);
         `CHK("reset value", 32'h0000_0000, q)
      end
      xfer(CTMR_ADDR_FCV_LO, 1'b1, 32'hFFFF_FFA5, q, e);
      xfer(CTMR_ADDR_FCV_HI, 1'b1, 32'hFFFF_FFFF, q, e);
      rd(CTMR_ADDR_FCV_LO, q);
      `CHK("fine low", 32'h0000_00A5, q)
      rd(CTMR_ADDR_FCV_HI, q);
      `CHK("fine high", 32'h0000_0003, q)
      wr(CTMR_ADDR_CNT_LO, 8'hFF);
      rd(CTMR_ADDR_CNT_LO, q);
      `CHK("count read only", 32'h0000_0000, q)
      xfer(8'h1C, 1'b1, 32'h0000_00FF, q, e);
      `CHK("unmapped write", 1'b1, e)
      xfer(8'h1C, 1'b0, 32'h0000_0000, q, e);
      `CHK("unmapped read", 33'h1_0000_0000, {e, q})
   endtask : testRegs
   task automatic testCount();
      logic [31:0] q;
      logic [31:0] p;
      logic [7:0]  m;
      cfg(8'h00, 10'h3FF, 3'h1);
      sweep(CTMR_ADDR_CNT_LO, 200, m);
      `CHK("period 128", 8'h7F, m)
      cfg(8'h00, 10'h3FF, 3'h6);
      sweep(CTMR_ADDR_CNT_HI, 400, m);
      `CHK("period 768", 8'h02, m)
      cfg(8'h00, 10'h3FF, 3'h0);
      sweep(CTMR_ADDR_CNT_HI, 400, m);
      `CHK("overflow", 8'h03, m)
      rd(CTMR_ADDR_STAT, q);
      `CHK("coarse flag set", 1'b1, q[CTMR_ST_CMF_BIT])
      cfg(8'h01, 10'h12C, 3'h1);
      sweep(CTMR_ADDR_CNT_HI, 150, m);
      `CHK("fine clear", 8'h01, m)
      rd(CTMR_ADDR_STAT, q);
      `CHK("coarse flag", 1'b0, q[CTMR_ST_CMF_BIT])
      `CHK("fine flag set", 1'b1, q[CTMR_ST_FMF_BIT])
      wr(CTMR_ADDR_CTRL0, 8'h01);
      rd(CTMR_ADDR_CNT_LO, p);
      repeat (20) @(posedge clk);
      rd(CTMR_ADDR_CNT_LO, q);
      `CHK("held count", p, q)
      wr(CTMR_ADDR_CTRL0, 8'h09);
      rd(CTMR_ADDR_CNT_LO, q);
      `CHK("restart", 1'b1, q < 32'h0000_0008)
   endtask : testCount
   task automatic cmpRow(input logic [7:0] c1, input logic i, f);
      cfg(c1, 10'h014, 3'h1);
      // Start level shows one edge after the on write completes
      @(posedge clk);
      `CHK("pin start", i, timerOutputPin)
      repeat (50) @(posedge clk);
      `CHK("pin after match", f, timerOutputPin)
   endtask : cmpRow
   task automatic testToggle();
      logic a;
      cfg(8'h31, 10'h014, 3'h1);
      repeat (30) @(posedge clk);
      a = timerOutputPin;
      repeat (20) @(posedge clk);
      `CHK("toggle", ~a, timerOutputPin)
   endtask : testToggle
   task automatic pwmRow(input logic [7:0] c1, input logic [9:0] f,
      input int w, input int h);
      int n = 0;
      cfg(c1, f, 3'h1);
      repeat (20) @(posedge clk);
      repeat (w) begin
         @(posedge clk);
         if (timerOutputPin === 1'b1) n++;
      end
      `CHK("pwm active", h, n)
   endtask : pwmRow
   task automatic results();
      $display("checks %0d mismatches %0d", totalChecks, failCount);
      if (failCount == 0 && totalChecks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      testRegs();
      testCount();
      cmpRow(8'h19, 1'b1, 1'b0);
      cmpRow(8'h09, 1'b1, 1'b1);
      cmpRow(8'h21, 1'b0, 1'b1);
      cmpRow(8'h01, 1'b0, 1'b0);
      cmpRow(8'h11, 1'b0, 1'b0);
      cmpRow(8'h29, 1'b1, 1'b1);
      cmpRow(8'h25, 1'b1, 1'b0);
      cmpRow(8'hE9, 1'b0, 1'b0);
      testToggle();
      pwmRow(8'hA9, 10'h020, 256, 64);
      pwmRow(8'hA0, 10'h020, 256, 192);
      pwmRow(8'hAA, 10'h0C8, 400, 256);
      pwmRow(8'hAA, 10'h064, 200, 200);
      pwmRow(8'h88, 10'h020, 256, 0);
      pwmRow(8'h98, 10'h020, 256, 256);
      pwmRow(8'hAC, 10'h020, 256, 192);
      results();
   end
   // Watchdog: about five times the expected run
   initial begin
      #330_000;
      failCount++;
      results();
   end
endmodule : ctmr_timer_tb_top
